// ===== hdl/adc_irq_pkg.sv
// Package with widths, counts and the event carrier types for the converter interrupt block
package adc_irq_pkg;
	localparam int unsigned GROUPS = 9;          // Scan groups in all
	localparam int unsigned SOLO_GROUPS = 5;     // Groups 0..4 with their own lines
	localparam int unsigned SHARED_GROUPS = 4;   // Groups 5..8 on one shared line
	localparam int unsigned LIMIT_TABLES = 8;    // Limiter tables 0..7
	localparam int unsigned MATCH_TABLES = 8;    // Compare tables 0..7
	localparam int unsigned SOLO_TABLES = 4;     // Tables 0..3 with their own lines
	localparam int unsigned COMPOSITES = 2;      // Composite conditions 0..1
	localparam int unsigned UNITS = 2;           // Converter units 0..1
	localparam int unsigned FIFO_DEPTH = 8;      // FIFO stages per group
	localparam int unsigned CNT_W = 4;           // Width of a vacant stage count
	localparam logic RESET_LEVEL = 1'b0;         // Value of every request after reset

	// Status coming from the converter core, one cycle per event except counts
	typedef struct packed {
		logic [GROUPS-1:0] scan_end;             // Scan finished, per group
		logic [GROUPS-1:0] fifo_ovf;             // FIFO overflow, per group
		logic [GROUPS*CNT_W-1:0] fifo_vacant;    // Vacant stages, per group
		logic [GROUPS*CNT_W-1:0] fifo_thresh;    // Programmed thresholds, per group
		logic [LIMIT_TABLES-1:0] clip;           // Limiter clip, per table
		logic [MATCH_TABLES-1:0] match;          // Compare match, per table
		logic [COMPOSITES*MATCH_TABLES-1:0] comp_sel; // Tables used by each composite
		logic [COMPOSITES-1:0] comp_and;         // 1: all selected, 0: any selected
		logic [UNITS-1:0] unit_err;              // Operational error, per unit
		logic [UNITS-1:0] res_ovf;               // Result overflow, per unit
		logic [UNITS-1:0] cal_done;              // Calibration finished, per unit
	} core_status_t;

	// Interrupt request pulses towards the system interrupt controller
	typedef struct packed {
		logic [SOLO_GROUPS-1:0] scan_end_req_group;
		logic scan_end_req_shared_hi;
		logic [SOLO_GROUPS-1:0] fifo_read_req_group;
		logic fifo_read_req_shared_hi;
		logic fifo_overflow_req;
		logic limiter_clip_req;
		logic [SOLO_TABLES-1:0] table_match_req;
		logic [COMPOSITES-1:0] composite_match_req;
		logic [UNITS-1:0] unit_error_req;
		logic [UNITS-1:0] result_overflow_req;
		logic [UNITS-1:0] calibration_done_req;
	} irq_req_t;

	// Event pulses towards the event link controller
	typedef struct packed {
		logic [SOLO_GROUPS-1:0] scan_end_evt;
		logic scan_end_shared_evt;
		logic fifo_read_shared_evt;
		logic [COMPOSITES-1:0] composite_evt;
	} link_evt_t;

	localparam int unsigned IRQ_W = $bits(irq_req_t);
endpackage

// ===== hdl/rise_pulse.sv
// Rising-edge to single pulse converter, one per condition bit
`timescale 1ns/1ps
module rise_pulse #(
	parameter int unsigned W = 1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] level,
	output logic [W-1:0] pulse
);
	logic [W-1:0] prev_q; // Level seen last cycle
	logic [W-1:0] prev_d;

	// Next state is just the present level
	always_comb begin
		prev_d = level;
	end

	// Register the level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= '0;
		end else begin
			prev_q <= prev_d;
		end
	end

	// One pulse per rising edge, per bit
	genvar b;
	generate
		for (b = 0; b < W; b++) begin : g_bit
			assign pulse[b] = level[b] & ~prev_q[b];
		end
	endgenerate
endmodule

// ===== hdl/adc_interrupt_event_gen.sv
// Interrupt and event generator for a two-unit, nine-group A/D converter
`timescale 1ns/1ps
module adc_interrupt_event_gen (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire adc_irq_pkg::core_status_t status,
	output adc_irq_pkg::irq_req_t irq_req,
	output adc_irq_pkg::link_evt_t link_evt
);
	localparam int unsigned G = adc_irq_pkg::GROUPS;
	localparam int unsigned W = adc_irq_pkg::CNT_W;
	localparam int unsigned T = adc_irq_pkg::MATCH_TABLES;

	logic rst_s1_q; // Reset release synchroniser, first stage
	logic rst_n_q;  // Reset used by the whole block
	logic rst_s1_d; // First stage next value
	logic rst_n_d;  // Second stage next value

	// Next values: ones ripple in behind the released reset
	always_comb begin
		rst_s1_d = 1'b1;
		rst_n_d = rst_s1_q;
	end

	// Release the reset through two flops, assert at once
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= rst_s1_d;
			rst_n_q <= rst_n_d;
		end
	end

	logic [G-1:0] fifo_low;    // Vacant count at or under threshold, per group
	logic [1:0] comp_hit;      // Composite condition met
	logic [G-1:0] fifo_req_p;  // Pulse on entering the low-vacancy state

	// Threshold compare per group
	genvar g;
	generate
		for (g = 0; g < G; g++) begin : g_fifo
			assign fifo_low[g] = status.fifo_vacant[g*W +: W] <= status.fifo_thresh[g*W +: W];
		end
	endgenerate

	// Composite conditions: all or any of the selected tables matching
	generate
		for (g = 0; g < adc_irq_pkg::COMPOSITES; g++) begin : g_comp
			logic [T-1:0] sel;
			assign sel = status.comp_sel[g*T +: T];
			assign comp_hit[g] = (sel != '0) && (status.comp_and[g] ?
				((status.match & sel) == sel) : ((status.match & sel) != '0));
		end
	endgenerate

	// FIFO level is a level condition: one request per entry at or under threshold
	rise_pulse #(.W(G)) u_fifo_edge (
		.sys_clk(sys_clk),
		.rst_n(rst_n_q),
		.level(fifo_low),
		.pulse(fifo_req_p)
	);

	logic [1:0] comp_prev_q; // Composite level last cycle, for one pulse per match
	logic [1:0] comp_prev_d;
	adc_irq_pkg::irq_req_t irq_d;
	adc_irq_pkg::irq_req_t irq_q;
	adc_irq_pkg::link_evt_t evt_d;
	adc_irq_pkg::link_evt_t evt_q;

	// Map core conditions onto request and event lines
	always_comb begin
		comp_prev_d = comp_hit;
		irq_d = '0;
		evt_d = '0;
		// Scan completion lines
		irq_d.scan_end_req_group = status.scan_end[4:0];
		irq_d.scan_end_req_shared_hi = |status.scan_end[8:5];
		// FIFO fill level lines, from the entry pulses
		irq_d.fifo_read_req_group = fifo_req_p[4:0];
		irq_d.fifo_read_req_shared_hi = |fifo_req_p[8:5];
		// Lines shared by every group or table
		irq_d.fifo_overflow_req = |status.fifo_ovf;
		irq_d.limiter_clip_req = |status.clip;
		// Compare table lines
		irq_d.table_match_req = status.match[3:0];
		irq_d.composite_match_req = comp_hit & ~comp_prev_q;
		// Per-unit lines
		irq_d.unit_error_req = status.unit_err;
		irq_d.result_overflow_req = status.res_ovf;
		irq_d.calibration_done_req = status.cal_done;
		// Event copies of the matching requests
		evt_d.scan_end_evt = irq_d.scan_end_req_group;
		evt_d.scan_end_shared_evt = irq_d.scan_end_req_shared_hi;
		evt_d.fifo_read_shared_evt = irq_d.fifo_read_req_shared_hi;
		evt_d.composite_evt = irq_d.composite_match_req;
	end

	// Outputs straight from flops, cleared in reset
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			irq_q <= '0;
			evt_q <= '0;
			comp_prev_q <= '0;
		end else begin
			irq_q <= irq_d;
			evt_q <= evt_d;
			comp_prev_q <= comp_prev_d;
		end
	end

	// Ports come straight from the output flops
	assign irq_req = irq_q;
	assign link_evt = evt_q;

	// Checks
	// Group 0 scan end gives request and event a cycle later
	AST_SCAN_SOLO: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		status.scan_end[0] |=> irq_req.scan_end_req_group[0] && link_evt.scan_end_evt[0])
		else $error("group 0 scan end not signalled");
	// Group 4 keeps its own line as well
	AST_SCAN_SOLO4: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		status.scan_end[4] |=> irq_req.scan_end_req_group[4] && link_evt.scan_end_evt[4])
		else $error("group 4 scan end not signalled");
	// Any of groups 5-8 drives the shared request
	AST_SCAN_SHARED: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		(|status.scan_end[8:5]) |=> irq_req.scan_end_req_shared_hi)
		else $error("shared scan end not signalled");
	// Shared scan end also reaches the event link
	AST_SCAN_SHARED_EVT: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		(|status.scan_end[8:5]) |=> link_evt.scan_end_shared_evt)
		else $error("shared scan end event missing");
	// Group 0 entering low vacancy requests a read
	AST_FIFO_SOLO: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		$rose(fifo_low[0]) |=> irq_req.fifo_read_req_group[0])
		else $error("group 0 FIFO request missing");
	// Group 0 read request lasts a single cycle
	AST_FIFO_SOLO_ONE: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		irq_req.fifo_read_req_group[0] |=> !irq_req.fifo_read_req_group[0])
		else $error("group 0 FIFO request longer than one cycle");
	// Shared read request and its event travel together
	AST_FIFO_SHARED: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		irq_req.fifo_read_req_shared_hi |-> link_evt.fifo_read_shared_evt)
		else $error("shared FIFO event mismatch");
	// Any of groups 5-8 newly low raises the shared request
	AST_FIFO_SHARED_EDGE: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		(|(fifo_low[8:5] & ~$past(fifo_low[8:5]))) |=>
		irq_req.fifo_read_req_shared_hi && link_evt.fifo_read_shared_evt)
		else $error("shared FIFO request missing");
	// Any overflow gives the single overflow request
	AST_OVF: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		(|status.fifo_ovf) |=> irq_req.fifo_overflow_req)
		else $error("FIFO overflow not signalled");
	// No overflow anywhere, no overflow request
	AST_NO_OVF: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		(status.fifo_ovf == '0) |=> !irq_req.fifo_overflow_req)
		else $error("spurious overflow request");
	// No clip anywhere, no clip request
	AST_CLIP: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		(status.clip == '0) |=> !irq_req.limiter_clip_req)
		else $error("spurious clip request");
	// A clip in any table raises the clip request
	AST_CLIP_ANY: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		(|status.clip) |=> irq_req.limiter_clip_req)
		else $error("clip request missing");
	// Table 3 match on its own line
	AST_MATCH: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		status.match[3] |=> irq_req.table_match_req[3])
		else $error("table 3 match missing");
	// Table 0 quiet keeps its line quiet
	AST_MATCH_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		!status.match[0] |=> !irq_req.table_match_req[0])
		else $error("spurious table 0 match request");
	// Composite 0 request lasts a single cycle
	AST_COMP_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		irq_req.composite_match_req[0] |=> !irq_req.composite_match_req[0])
		else $error("composite request longer than one cycle");
	// Composite 1 request lasts a single cycle
	AST_COMP_PULSE1: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		irq_req.composite_match_req[1] |=> !irq_req.composite_match_req[1])
		else $error("composite 1 request longer than one cycle");
	// Composite 1 becoming true gives request and event
	AST_COMP_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		$rose(comp_hit[1]) |=> irq_req.composite_match_req[1] && link_evt.composite_evt[1])
		else $error("composite 1 request missing");
	// An empty composite 0 selection never fires its request
	AST_COMP_EMPTY: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		(status.comp_sel[7:0] == 8'h00) |=> !irq_req.composite_match_req[0])
		else $error("composite 0 fired with no tables selected");
	// Unit lines follow their conditions
	AST_UNIT: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		status.unit_err[1] && status.res_ovf[0] && status.cal_done[1] |=>
		irq_req.unit_error_req[1] && irq_req.result_overflow_req[0]
		&& irq_req.calibration_done_req[1])
		else $error("unit request missing");
	// Unit 0 error on its own line
	AST_ERR0: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		status.unit_err[0] |=> irq_req.unit_error_req[0])
		else $error("unit 0 error request missing");
	// Unit 1 result overflow on its own line
	AST_RESOVF1: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		status.res_ovf[1] |=> irq_req.result_overflow_req[1])
		else $error("unit 1 overflow request missing");
	// Unit 0 calibration end on its own line
	AST_CAL0: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
		status.cal_done[0] |=> irq_req.calibration_done_req[0])
		else $error("unit 0 calibration request missing");
	// Requests quiet while reset holds
	AST_RESET: assert property (@(posedge sys_clk) !rst_n_q |-> irq_req == '0)
		else $error("request active in reset");
	// Events quiet while reset holds
	AST_RESET_EVT: assert property (@(posedge sys_clk) !rst_n_q |-> link_evt == '0)
		else $error("event active in reset");

	// Main scenarios seen
	COV_SCAN: cover property (@(posedge sys_clk) irq_req.scan_end_req_shared_hi);
	COV_FIFO: cover property (@(posedge sys_clk) irq_req.fifo_read_req_group[2]);
	COV_COMP: cover property (@(posedge sys_clk) link_evt.composite_evt[1]);
	COV_OVF: cover property (@(posedge sys_clk) irq_req.fifo_overflow_req && irq_req.limiter_clip_req);
	COV_CAL: cover property (@(posedge sys_clk) irq_req.calibration_done_req[0]);
endmodule

// ===== bench/irq_sink.sv
// Far-side model: interrupt controller pending latch and event link counter
`timescale 1ns/1ps
module irq_sink (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire adc_irq_pkg::irq_req_t irq_req,
	input wire adc_irq_pkg::link_evt_t link_evt,
	output logic [adc_irq_pkg::IRQ_W-1:0] pending_q,
	output logic [31:0] evt_count_q,
	output logic scan_trigger
);
	// Shared scan-end event routed onward as a scan trigger
	assign scan_trigger = link_evt.scan_end_shared_evt;
	// Latch request pulses until reset, count event pulses
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pending_q <= '0;
			evt_count_q <= '0;
		end else begin
			pending_q <= pending_q | irq_req;
			evt_count_q <= evt_count_q + 32'($countones(link_evt));
		end
	end
endmodule

// ===== bench/adc_interrupt_event_gen_tb.sv
// Self-checking bench for the converter interrupt and event generator
`timescale 1ns/1ps
module adc_interrupt_event_gen_tb;
	logic sys_clk;
	logic reset_n;
	logic check_en;
	logic [31:0] seed;
	logic [31:0] evt_count;
	logic [31:0] evt_exp = '0;
	logic [adc_irq_pkg::IRQ_W-1:0] pending;
	logic [adc_irq_pkg::IRQ_W-1:0] pend_exp = '0;
	logic scan_trigger;
	adc_irq_pkg::core_status_t status;
	adc_irq_pkg::core_status_t prev_status;
	adc_irq_pkg::irq_req_t irq_req;
	adc_irq_pkg::link_evt_t link_evt;
	adc_irq_pkg::irq_req_t q_irq[$];
	adc_irq_pkg::link_evt_t q_evt[$];
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	adc_interrupt_event_gen u_adc_interrupt_event_gen (.sys_clk(sys_clk), .reset_n(reset_n),
		.status(status), .irq_req(irq_req), .link_evt(link_evt));
	irq_sink u_irq_sink (.sys_clk(sys_clk), .reset_n(reset_n), .irq_req(irq_req),
		.link_evt(link_evt), .pending_q(pending), .evt_count_q(evt_count),
		.scan_trigger(scan_trigger));
	// Free-running clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Composite condition level for one composite
	function automatic logic hit(input adc_irq_pkg::core_status_t c, input int m);
		logic [7:0] sel;
		sel = c.comp_sel[m*8+:8];
		return (sel != 8'h00) && (c.comp_and[m] ? ((c.match & sel) == sel) : |(c.match & sel));
	endfunction
	// Expected outputs from the sampled status and the one before it
	task automatic model(input adc_irq_pkg::core_status_t c, input adc_irq_pkg::core_status_t p);
		adc_irq_pkg::irq_req_t r;
		adc_irq_pkg::link_evt_t e;
		logic [8:0] lo;
		logic [8:0] lp;
		for (int g = 0; g < 9; g++) begin
			lo[g] = c.fifo_vacant[g*4+:4] <= c.fifo_thresh[g*4+:4];
			lp[g] = p.fifo_vacant[g*4+:4] <= p.fifo_thresh[g*4+:4];
		end
		r.scan_end_req_group = c.scan_end[4:0];
		r.scan_end_req_shared_hi = |c.scan_end[8:5];
		r.fifo_read_req_group = lo[4:0] & ~lp[4:0];
		r.fifo_read_req_shared_hi = |(lo[8:5] & ~lp[8:5]);
		r.fifo_overflow_req = |c.fifo_ovf;
		r.limiter_clip_req = |c.clip;
		r.table_match_req = c.match[3:0];
		r.composite_match_req = {hit(c, 1) & ~hit(p, 1), hit(c, 0) & ~hit(p, 0)};
		r.unit_error_req = c.unit_err;
		r.result_overflow_req = c.res_ovf;
		r.calibration_done_req = c.cal_done;
		e = {r.scan_end_req_group, r.scan_end_req_shared_hi, r.fifo_read_req_shared_hi,
			r.composite_match_req};
		q_irq.push_back(r);
		q_evt.push_back(e);
	endtask
	// Random status; pulses never repeat on adjacent cycles, every FIFO moves on its own
	function automatic adc_irq_pkg::core_status_t next_status(input adc_irq_pkg::core_status_t s);
		adc_irq_pkg::core_status_t n;
		n = s;
		for (int g = 0; g < 9; g++) begin
			seed = xs(seed);
			n.fifo_vacant[g*4+:4] = 4'(seed[7:0] % 9);
			n.fifo_thresh[g*4+:4] = seed[11:8] & 4'h7;
		end
		seed = xs(seed);
		n.scan_end = seed[8:0] & ~s.scan_end;
		n.fifo_ovf = seed[17:9] & ~s.fifo_ovf;
		n.clip = seed[25:18] & ~s.clip;
		n.unit_err = seed[27:26] & ~s.unit_err;
		n.res_ovf = seed[29:28] & ~s.res_ovf;
		n.cal_done = seed[31:30] & ~s.cal_done;
		seed = xs(seed);
		n.match = seed[7:0] & ~s.match;
		n.comp_sel = seed[23:8];
		n.comp_and = seed[25:24];
		return n;
	endfunction
	task automatic cmp_irq(input string nm, input logic [adc_irq_pkg::IRQ_W-1:0] ex, got);
		compares++;
		if (got !== ex) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic cmp_evt(input string nm, input logic [31:0] ex, got);
		compares++;
		if (got !== ex) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic end_sim;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Note expectations and track the previous sample; cut a hang short
	always @(posedge sys_clk) begin
		if (check_en) model(status, prev_status);
		prev_status <= status;
		cycles++;
		if (cycles > 3000) begin
			errors++;
			end_sim();
		end
	end
	// Take the oldest note whenever a result is due and compare
	always @(posedge sys_clk) begin
		#1;
		if (q_irq.size() > 0) begin
			pend_exp = pend_exp | q_irq[0];
			evt_exp = evt_exp + 32'($countones(q_evt[0]));
			cmp_evt("scan_trigger", 32'(q_evt[0].scan_end_shared_evt), 32'(scan_trigger));
			cmp_irq("irq_req", q_irq.pop_front(), irq_req);
			cmp_evt("link_evt", 32'(q_evt.pop_front()), 32'(link_evt));
		end
	end
	// Main sequence
	initial begin
		seed = 32'h0d6913db;
		check_en = 1'b0;
		reset_n = 1'b0;
		status = '0;
		status.fifo_vacant = {9{4'h8}};
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check_en <= 1'b1;
		repeat (600) begin
			@(posedge sys_clk);
			status <= next_status(status);
		end
		@(posedge sys_clk);
		status <= '0;
		repeat (2) @(posedge sys_clk);
		check_en <= 1'b0;
		repeat (3) @(posedge sys_clk);
		cmp_irq("pending", pend_exp, pending);
		cmp_evt("evt_count", evt_exp, evt_count);
		status.scan_end <= '1;
		status.fifo_ovf <= '1;
		reset_n <= 1'b0;
		@(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) begin
			#1;
			cmp_irq("reset_irq", '0, irq_req);
			cmp_evt("reset_evt", 32'h0, 32'(link_evt));
			@(posedge sys_clk);
		end
		// Third edge after release: held scan ends, overflows and low FIFOs come through
		#1;
		cmp_irq("irq_rst", {5'h1f, 1'b1, 5'h1f, 2'h3, 13'h0000}, irq_req);
		cmp_evt("evt_rst", 32'h000001fc, 32'(link_evt));
		end_sim();
	end
endmodule
